// File: core/diag_regs_consts.svh
// constants for the diagnostic and process register view
`ifndef DIAG_REGS_CONSTS_SVH
`define DIAG_REGS_CONSTS_SVH
`define ADDR_STATUS_WORD      16'h1F3C
`define ADDR_DIAG_FLAGS       16'h1F3D
`define ADDR_FAULT_GROUP      16'h1F3E
`define ADDR_INPUT_WORD       16'h1F40
`define ADDR_OUTPUT_WORD      16'h2328
`define BIT_OUT_SHORT         0
`define BIT_SENS_UNDER        2
`define BIT_SENS_SURGE        3
`define BIT_SENS_SHORT        4
`define BIT_ACT_UNDER         6
`define BIT_ACT_SURGE         7
`define BIT_ACT_SHORT         8
`define BIT_OVERTEMP          10
`define BIT_GENERAL_ERROR     0
`define GROUP_NONE            16'h0000
`define GROUP_OUT_1_4         16'h0001
`define GROUP_OUT_5_8         16'h0002
`define EXC_ILLEGAL_ADDRESS   8'h02
`define EXC_NONE              8'h00
`define HIGH_BYTE_ZERO        8'h00
`define FACTORY_SWITCH_POS    4'hF
`define OUTPUT_RESET          8'h00
`define CONNECT_READY_MS      350
`define CYCLIC_READY_MS       500
`define CLOCK_HZ              50000000
`endif

// File: core/diag_regs_pkg.sv
// types shared by the register view
package diag_regs_pkg;
    typedef logic [15:0] reg_word_t;
    typedef logic [7:0]  io_byte_t;
    typedef enum logic [1:0] {
        boot_wait,
        connect_ready,
        cyclic_ready
    } start_state_t;
endpackage : diag_regs_pkg

// File: core/startup_timer.sv
// counts power-up time and announces readiness stages
`timescale 1ns/100ps
`default_nettype none
`include "diag_regs_consts.svh"
module startup_timer #(
    parameter int CONNECT_CYCLES = (`CONNECT_READY_MS * (`CLOCK_HZ / 1000)) - 1,
    parameter int CYCLIC_CYCLES  = (`CYCLIC_READY_MS * (`CLOCK_HZ / 1000)) - 1
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic clk_en,
    output var  logic connect_ok,
    output var  logic cyclic_ok
);
    import diag_regs_pkg::*;

    start_state_t state;
    logic [31:0]  count;
    // longest times round down, so readiness comes strictly before the limit
    wire          hit_connect = (count == 32'(CONNECT_CYCLES - 1));
    wire          hit_cyclic  = (count == 32'(CYCLIC_CYCLES - 1));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= boot_wait;
            count <= 32'h0;
        end else if (clk_en) begin
            if (state != cyclic_ready)
                count <= count + 32'h1;
            case (state)
                boot_wait:     if (hit_connect) state <= connect_ready;
                connect_ready: if (hit_cyclic)  state <= cyclic_ready;
                cyclic_ready:  state <= cyclic_ready;
                default:       state <= boot_wait;
            endcase
        end
    end

    assign connect_ok = (state != boot_wait);
    assign cyclic_ok  = (state == cyclic_ready);
endmodule : startup_timer
`default_nettype wire

// File: core/fault_group_enc.sv
// encodes which output group holds a short circuit
`timescale 1ns/100ps
`default_nettype none
`include "diag_regs_consts.svh"
module fault_group_enc (
    input  wire logic [7:0]  out_short,
    output var  logic [15:0] group_code
);
    wire low_group  = |out_short[3:0];
    wire high_group = |out_short[7:4];
    // lower group wins when both are shorted; flag bit 0 only shows that some output is shorted
    assign group_code = low_group  ? `GROUP_OUT_1_4 :
                        high_group ? `GROUP_OUT_5_8 : `GROUP_NONE;
endmodule : fault_group_enc
`default_nettype wire

// File: core/modbus_diag_process_regs.sv
// register view of diagnostics and process data for the modbus client
// How it works
// - output short sets diagnostic flag bit 0
// - sensor supply faults in bits 2,3,4
// - actuator supply faults in bits 6,7,8
// - overtemperature sets bit 10
// - no short gives group code 0000
// - group 0001 outputs 1-4, 0002 outputs 5-8
// - inputs in low byte, bit n input n+1
// - outputs from low byte, bit n output n+1
// - words are big-endian, mapped one to one
// - byte data low byte, high reads 00
// - connection requests accepted under 350 ms
// - cyclic process data ready under 500 ms
// - switch position 0F restores defaults
// - read-only writes dropped, exception code 02
// - general error bit follows any diagnostic flag
`timescale 1ns/100ps
`default_nettype none
`include "diag_regs_consts.svh"
module modbus_diag_process_regs #(
    parameter int CONNECT_CYCLES = (`CONNECT_READY_MS * (`CLOCK_HZ / 1000)) - 1,
    parameter int CYCLIC_CYCLES  = (`CYCLIC_READY_MS * (`CLOCK_HZ / 1000)) - 1
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   clk_en,
    input  wire logic                   req_valid,
    input  wire logic                   req_write,
    input  wire logic [15:0]            req_addr,
    input  wire diag_regs_pkg::reg_word_t req_wdata,
    output var  logic                   rsp_valid,
    output var  diag_regs_pkg::reg_word_t rsp_rdata,
    output var  logic [7:0]             rsp_exception,
    input  wire diag_regs_pkg::io_byte_t device_input_channel,
    output var  diag_regs_pkg::io_byte_t device_output_channel,
    input  wire logic [7:0]             out_short,
    input  wire logic                   sens_under,
    input  wire logic                   sens_surge,
    input  wire logic                   sens_short,
    input  wire logic                   act_under,
    input  wire logic                   act_surge,
    input  wire logic                   act_short,
    input  wire logic                   overtemp,
    input  wire logic [3:0]             rotary_switch,
    output var  logic                   connect_ready_out,
    output var  logic                   cyclic_ready_out,
    output var  logic                   defaults_restored
);
    import diag_regs_pkg::*;

    reg_word_t diag_flags;
    reg_word_t fault_group;
    reg_word_t status_word;
    io_byte_t  input_latch;
    io_byte_t  output_byte;
    logic      connect_ok;
    logic      cyclic_ok;
    logic [15:0] group_code;

    startup_timer #(
        .CONNECT_CYCLES (CONNECT_CYCLES),
        .CYCLIC_CYCLES  (CYCLIC_CYCLES)
    ) u_timer (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .clk_en     (clk_en),
        .connect_ok (connect_ok),
        .cyclic_ok  (cyclic_ok)
    );

    fault_group_enc u_group (
        .out_short  (out_short),
        .group_code (group_code)
    );

    // live fault image; reserved positions stay zero
    reg_word_t next_diag_flags;
    always_comb begin
        next_diag_flags = 16'h0000;
        next_diag_flags[`BIT_OUT_SHORT]  = |out_short;
        next_diag_flags[`BIT_SENS_UNDER] = sens_under;
        next_diag_flags[`BIT_SENS_SURGE] = sens_surge;
        next_diag_flags[`BIT_SENS_SHORT] = sens_short;
        next_diag_flags[`BIT_ACT_UNDER]  = act_under;
        next_diag_flags[`BIT_ACT_SURGE]  = act_surge;
        next_diag_flags[`BIT_ACT_SHORT]  = act_short;
        next_diag_flags[`BIT_OVERTEMP]   = overtemp;
    end

    reg_word_t next_status;
    always_comb begin
        next_status = 16'h0000;
        next_status[`BIT_GENERAL_ERROR] = |next_diag_flags;
    end

    function automatic reg_word_t low_byte_word(input io_byte_t b);
        low_byte_word = {`HIGH_BYTE_ZERO, b};
    endfunction : low_byte_word

    // address decode
    wire hit_status = (req_addr == `ADDR_STATUS_WORD);
    wire hit_diag   = (req_addr == `ADDR_DIAG_FLAGS);
    wire hit_group  = (req_addr == `ADDR_FAULT_GROUP);
    wire hit_input  = (req_addr == `ADDR_INPUT_WORD);
    wire hit_output = (req_addr == `ADDR_OUTPUT_WORD);
    wire hit_ro     = hit_status | hit_diag | hit_group | hit_input;
    wire hit_any    = hit_ro | hit_output;
    // requests before connection readiness are not answered at all
    wire accept     = req_valid & connect_ok;
    wire do_write   = accept & req_write & hit_output & cyclic_ok;
    wire factory    = (rotary_switch == `FACTORY_SWITCH_POS);

    // whole words go out as stored; byte order is the transport's job
    wire reg_word_t read_mux =
        hit_status ? status_word :
        hit_diag   ? diag_flags :
        hit_group  ? fault_group :
        hit_input  ? low_byte_word(input_latch) :
        hit_output ? low_byte_word(output_byte) : 16'h0000;

    // read-only or unmapped writes, and unmapped reads, take exception 02
    wire refuse = (req_write & ~hit_output) | ~hit_any;
    // output writes before cyclic readiness are also refused
    wire early  = req_write & hit_output & ~cyclic_ok;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            diag_flags  <= 16'h0000;
            fault_group <= `GROUP_NONE;
            status_word <= 16'h0000;
            input_latch <= 8'h00;
        end else if (clk_en) begin
            diag_flags  <= next_diag_flags;
            fault_group <= group_code;
            status_word <= next_status;
            input_latch <= device_input_channel;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            output_byte <= `OUTPUT_RESET;
        end else if (clk_en) begin
            if (factory)
                output_byte <= `OUTPUT_RESET;
            else if (do_write)
                output_byte <= req_wdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rsp_valid     <= 1'b0;
            rsp_rdata     <= 16'h0000;
            rsp_exception <= `EXC_NONE;
        end else if (clk_en) begin
            rsp_valid     <= accept;
            rsp_rdata     <= (accept & ~req_write & hit_any) ? read_mux
                                                             : 16'h0000;
            rsp_exception <= (accept & (refuse | early))
                             ? `EXC_ILLEGAL_ADDRESS : `EXC_NONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            device_output_channel <= `OUTPUT_RESET;
            connect_ready_out     <= 1'b0;
            cyclic_ready_out      <= 1'b0;
            defaults_restored     <= 1'b0;
        end else if (clk_en) begin
            device_output_channel <= factory ? `OUTPUT_RESET
                                             : output_byte;
            connect_ready_out     <= connect_ok;
            cyclic_ready_out      <= cyclic_ok;
            defaults_restored     <= factory;
        end
    end
endmodule : modbus_diag_process_regs
`default_nettype wire

// File: testbench/diag_regs_props.sv
// port-level assertions for the register view
`timescale 1ns/100ps
`default_nettype none
module diag_regs_props #(
    parameter int CONNECT_CYCLES = 20,
    parameter int CYCLIC_CYCLES  = 40
) (
    input wire logic                     sys_clk,
    input wire logic                     rst,
    input wire logic                     clk_en,
    input wire logic                     req_valid,
    input wire logic                     req_write,
    input wire logic [15:0]              req_addr,
    input wire diag_regs_pkg::reg_word_t req_wdata,
    input wire logic                     rsp_valid,
    input wire diag_regs_pkg::reg_word_t rsp_rdata,
    input wire logic [7:0]               rsp_exception,
    input wire diag_regs_pkg::io_byte_t  device_output_channel,
    input wire logic [7:0]               out_short,
    input wire logic [3:0]               rotary_switch,
    input wire logic                     connect_ready_out,
    input wire logic                     cyclic_ready_out,
    input wire logic                     defaults_restored
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_take;
        req_valid && clk_en && connect_ready_out;
    endsequence
    sequence s_out_wr;
        s_take ##0 req_write && req_addr == 16'h2328 && cyclic_ready_out;
    endsequence
    property p_answer; s_take |=> rsp_valid; endproperty
    property p_quiet; clk_en && !req_valid |=> !rsp_valid; endproperty
    property p_ro; s_take ##0 req_write && req_addr == 16'h1F3D
        |=> rsp_exception == 8'h02; endproperty
    property p_hi; s_take ##0 !req_write && req_addr == 16'h1F40
        |=> rsp_rdata[15:8] == 8'h00; endproperty
    property p_out; s_out_wr ##0 rotary_switch != 4'hF ##1
        rotary_switch != 4'hF
        |=> device_output_channel == $past(req_wdata[7:0], 2); endproperty
    property p_dflt; (rotary_switch == 4'hF && clk_en) [*3]
        |-> defaults_restored && device_output_channel == 8'h00; endproperty
    property p_none; out_short == 8'h00 [*2] ##0 s_take ##0 !req_write
        && req_addr == 16'h1F3E |=> rsp_rdata == 16'h0000; endproperty
    property p_order; cyclic_ready_out |-> connect_ready_out; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    a_quiet: assert property (p_quiet) else $error("stray answer");
    a_ro: assert property (p_ro) else $error("ro write taken");
    a_hi: assert property (p_hi) else $error("high byte set");
    a_out: assert property (p_out) else $error("output wrong");
    a_dflt: assert property (p_dflt) else $error("no defaults");
    a_none: assert property (p_none) else $error("group not 0");
    a_order: assert property (p_order) else $error("bad order");
endmodule : diag_regs_props
bind modbus_diag_process_regs diag_regs_props #(
    .CONNECT_CYCLES(CONNECT_CYCLES), .CYCLIC_CYCLES(CYCLIC_CYCLES)
) i_props (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_exception(rsp_exception), .out_short(out_short),
    .device_output_channel(device_output_channel),
    .rotary_switch(rotary_switch), .connect_ready_out(connect_ready_out),
    .cyclic_ready_out(cyclic_ready_out),
    .defaults_restored(defaults_restored));
`default_nettype wire

// File: testbench/modbus_client.sv
// client model issuing single register transfers
`timescale 1ns/100ps
`default_nettype none
module modbus_client (
    input  wire logic                     sys_clk,
    output var  logic                     req_valid,
    output var  logic                     req_write,
    output var  logic [15:0]              req_addr,
    output var  diag_regs_pkg::reg_word_t req_wdata,
    input  wire logic                     rsp_valid,
    input  wire diag_regs_pkg::reg_word_t rsp_rdata,
    input  wire logic [7:0]               rsp_exception
);
    import diag_regs_pkg::*;
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 16'h0000;
        req_wdata = 16'h0000;
    end
    task automatic xfer(input logic w, input logic [15:0] a,
                        input reg_word_t d, output reg_word_t rd,
                        output logic [7:0] ex);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        // idle lines flip so a stale word is never mistaken for data
        req_addr <= ~a;
        req_wdata <= ~d;
        #1;
        rd = rsp_rdata;
        ex = (rsp_valid === 1'b1) ? rsp_exception : 8'hFF;
    endtask : xfer
endmodule : modbus_client
`default_nettype wire

// File: testbench/test_modbus_diag_process_regs.sv
// self-checking bench for the diagnostic and process registers
`timescale 1ns/100ps
`default_nettype none
module test_modbus_diag_process_regs;
    import diag_regs_pkg::*;
    logic sys_clk, rst, rv, rw, vld, cr, yr, dr, ce;
    logic [15:0] ra;
    reg_word_t wd, rdat, rd;
    logic [7:0] exc, ex, osh;
    io_byte_t din, dout;
    logic [6:0] fv;
    logic [3:0] sw;
    int n_fail, n_compared, cyc;
    logic [15:0] fbit [7] = '{16'h4, 16'h8, 16'h10, 16'h40, 16'h80,
                              16'h100, 16'h400};
    logic [15:0] ro [4] = '{16'h1F3C, 16'h1F3D, 16'h1F3E, 16'h1F40};
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    modbus_client i_cli (.sys_clk(sys_clk), .req_valid(rv), .req_write(rw),
        .req_addr(ra), .req_wdata(wd), .rsp_valid(vld), .rsp_rdata(rdat),
        .rsp_exception(exc));
    modbus_diag_process_regs #(.CONNECT_CYCLES(20), .CYCLIC_CYCLES(40))
    i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(ce), .req_valid(rv),
        .req_write(rw), .req_addr(ra), .req_wdata(wd), .rsp_valid(vld),
        .rsp_rdata(rdat), .rsp_exception(exc), .device_input_channel(din),
        .device_output_channel(dout), .out_short(osh), .sens_under(fv[0]),
        .sens_surge(fv[1]), .sens_short(fv[2]), .act_under(fv[3]),
        .act_surge(fv[4]), .act_short(fv[5]), .overtemp(fv[6]),
        .rotary_switch(sw), .connect_ready_out(cr),
        .cyclic_ready_out(yr), .defaults_restored(dr));
    task automatic chk(input string nm, input logic [15:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task close_out;
        if (n_fail == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    task automatic faults(input logic [6:0] f, input logic [7:0] s,
                          input logic [15:0] ef, eg);
        @(posedge sys_clk);
        fv <= f;
        osh <= s;
        repeat (3) @(posedge sys_clk);
        i_cli.xfer(1'b0, 16'h1F3D, 16'h0, rd, ex);
        chk("flags", rd, ef);
        i_cli.xfer(1'b0, 16'h1F3E, 16'h0, rd, ex);
        chk("group", rd, eg);
        i_cli.xfer(1'b0, 16'h1F3C, 16'h0, rd, ex);
        chk("status", rd, {15'h0, |ef});
    endtask : faults
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        rst = 1'b1; din = 8'h5C; osh = 8'h00; fv = 7'h00; sw = 4'h0;
        n_fail = 0; n_compared = 0; cyc = 0; ce = 1'b1;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        i_cli.xfer(1'b0, 16'h1F40, 16'h0, rd, ex);
        chk("early request", {8'h0, ex}, 16'h00FF);
        chk("connect ready early", {15'h0, cr}, 16'h0000);
        while (cr !== 1'b1) @(posedge sys_clk);
        chk("cyclic ready early", {15'h0, yr}, 16'h0000);
        i_cli.xfer(1'b1, 16'h2328, 16'h00FF, rd, ex);
        chk("early output write", {8'h0, ex}, 16'h0002);
        i_cli.xfer(1'b0, 16'h1F40, 16'h0, rd, ex);
        chk("input word", rd, 16'h005C);
        while (yr !== 1'b1) @(posedge sys_clk);
        i_cli.xfer(1'b1, 16'h2328, 16'h12A5, rd, ex);
        chk("output write", {8'h0, ex}, 16'h0000);
        i_cli.xfer(1'b0, 16'h2328, 16'h0, rd, ex);
        chk("output readback", rd, 16'h00A5);
        chk("output pins", {8'h0, dout}, 16'h00A5);
        for (int i = 0; i < 4; i++) begin
            i_cli.xfer(1'b1, ro[i], 16'hFFFF, rd, ex);
            chk("read-only write", {8'h0, ex}, 16'h0002);
        end
        i_cli.xfer(1'b0, 16'h1F3F, 16'h0, rd, ex);
        chk("unmapped read", {8'h0, ex}, 16'h0002);
        for (int i = 0; i < 7; i++) faults(7'h1 << i, 8'h0, fbit[i], 16'h0);
        faults(7'h7F, 8'h00, 16'h05DC, 16'h0000);
        faults(7'h00, 8'h01, 16'h0001, 16'h0001);
        faults(7'h00, 8'h80, 16'h0001, 16'h0002);
        faults(7'h00, 8'h00, 16'h0000, 16'h0000);
        // a low enable must freeze the pins even with the switch at 0F
        @(posedge sys_clk);
        ce <= 1'b0;
        sw <= 4'hF;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("frozen pins", {8'h0, dout}, 16'h00A5);
        chk("frozen flag", {15'h0, dr}, 16'h0000);
        @(posedge sys_clk);
        ce <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("defaults pins", {8'h0, dout}, 16'h0000);
        chk("defaults flag", {15'h0, dr}, 16'h0001);
        close_out();
    end
endmodule : test_modbus_diag_process_regs
`default_nettype wire
